// ---- burst_spi_host_slave.sv ----
`timescale 1ns/100ps
`include "burst_spi_params.svh"
module burst_spi_host_slave import burst_spi_pkg::*; (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic LINK_SCLK_IN,
  input wire logic PORT_SELECT_N_IN,
  input wire logic MOSI_IN,
  output logic MISO_OUT,
  output logic MISO_OE_OUT,
  input wire logic MODE_SELECT_IN,
  output logic PORT_MODE_OUT,
  output logic ACC_REQ_OUT,
  output logic ACC_BURST_OUT,
  output logic ACC_WRITE_OUT,
  output logic [23:0] ACC_ADDR_OUT,
  output logic [15:0] ACC_WDATA_OUT,
  input wire logic ACC_ACK_IN,
  input wire logic [15:0] ACC_RDATA_IN,
  input wire logic ACC_ERR_IN,
  output logic SLEEP_ALLOW_OUT,
  output logic WAKE_REQ_OUT,
  input wire logic WAKE_DONE_IN,
  output logic HOST_INT_OUT
);
  // ---- Link clock domain ----
  wire frame_rst_n; // Frame logic held while select is high
  wire [7:0] rx_byte; // Byte being completed
  wire rx_last; // Last bit of a byte this edge
  link_state_type state; // Frame phase
  logic [7:0] cmd; // Command byte
  logic [23:0] addr; // Address being gathered
  logic [15:0] len_left; // Bytes still to move
  logic [7:0] wdata; // First write byte
  logic [3:0] fcnt; // Byte count inside a phase
  logic [7:0] tx; // Output byte being shifted
  logic bw_first; // Next burst write byte is the first
  logic len_en; // Length field enable
  logic [3:0] pad_cnt; // Read pad count
  logic sleep_allow; // Deep sleep permission
  logic wake_req; // Wake-up request
  logic clr_tgl; // Interrupt clear event toggle
  logic req_tgl; // Access request toggle
  logic [23:0] q_addr; // Request fields, held with the toggle
  logic [15:0] q_wdata;
  logic q_write;
  logic q_burst;
  logic q_start;
  wire ack_sync; // Answer toggle seen on link clock
  wire port_on; // Port mode seen on link clock
  wire wake_done_l; // Wake status seen on link clock
  // ---- Core clock domain ----
  core_state_type cstate; // Access phase
  wire req_sync; // Request toggle seen on core clock
  wire clr_sync; // Clear toggle seen on core clock
  logic req_seen; // Last request toggle handled
  logic clr_seen; // Last clear toggle handled
  logic ack_tgl; // Answer toggle
  logic [15:0] ans_rdata; // Answer data, held with the toggle
  logic ans_err; // Answer failure, held with the toggle
  logic [23:0] ptr; // Buffer pointer for bursts
  logic wake_seen; // Wake completion edge memory

  // Frame reset from the select pin
  // select high ends frame
  assign frame_rst_n = ARST_N_IN & ~PORT_SELECT_N_IN;

  // Byte assembler, sampling on the rising edge
  rx_shift u_rx (
    .clk_in(LINK_SCLK_IN),
    .arst_n_in(frame_rst_n),
    .bit_in(MOSI_IN),
    .byte_out(rx_byte),
    .last_out(rx_last)
  );

  // Crossings into the link domain
  bit_sync u_ack (
    .clk_in(LINK_SCLK_IN),
    .arst_n_in(ARST_N_IN),
    .d_in(ack_tgl),
    .q_out(ack_sync)
  );
  bit_sync u_mode (
    .clk_in(LINK_SCLK_IN),
    .arst_n_in(ARST_N_IN),
    .d_in(PORT_MODE_OUT),
    .q_out(port_on)
  );
  bit_sync u_wdone (
    .clk_in(LINK_SCLK_IN),
    .arst_n_in(ARST_N_IN),
    .d_in(WAKE_DONE_IN),
    .q_out(wake_done_l)
  );

  // Command decode
  // burst bit in command
  wire is_burst = cmd[`CMD_BURST_BIT];
  wire is_write = cmd[`CMD_WRITE_BIT];
  wire done = (ack_sync == req_tgl); // No request outstanding
  // Address including the byte now arriving
  wire in_addr = (state == S_ADDR);
  wire [23:0] cur_addr = in_addr ? {addr[15:0], rx_byte} : addr;
  wire cur_f0 = (cur_addr[`FUNC_MSB:`FUNC_LSB] == `FUNC_ZERO);
  wire [7:0] reg_sel = cur_addr[7:0];
  // Length including the byte now arriving
  wire [15:0] hdr_len = {len_left[7:0], rx_byte};
  wire hdr_can = !len_en | (hdr_len != 16'h0000);
  wire moving = !len_en | (len_left != 16'h0000);
  wire more = !len_en | (len_left > 16'h0001);

  // Header end: last address byte, or last length byte
  // length only for bursts
  wire addr_end = in_addr & (fcnt == `ADDR_LAST_BYTE);
  wire len_next = is_burst & len_en;
  wire len_end = (state == S_LEN) & (fcnt == `LEN_LAST_BYTE);
  wire hdr_end = rx_last & ((addr_end & !len_next) | len_end);
  wire len_go = rx_last & addr_end & len_next;

  // Access requests toward the core side
  // bursts never reach function 0 registers
  wire rd_issue = hdr_end & !is_write & !cur_f0 & (!is_burst | hdr_can);
  wire wr_issue = rx_last & (state == S_WDATA) & (fcnt == 4'h1) & !cur_f0;
  wire bw_issue = rx_last & (state == S_BWR) & moving & !cur_f0;
  // fetch next byte while this one shifts
  wire br_slot = ((state == S_ERR) & is_burst) | (state == S_BRD);
  wire br_issue = rx_last & br_slot & moving & more & !cur_f0;
  wire any_issue = port_on & (rd_issue | wr_issue | bw_issue | br_issue);
  wire issue_go = any_issue & done;
  wire busy_now = any_issue & !done;
  wire issue_wr = wr_issue | bw_issue;
  wire issue_start = rd_issue | (bw_issue & bw_first);
  wire [15:0] issue_wdata = wr_issue ? {wdata, rx_byte} : {8'h00, rx_byte};

  // Function 0 writes, served without the core clock
  // function 0 alive in deep sleep
  wire f0_wr = port_on & rx_last & (state == S_WDATA) & (fcnt == 4'h1) &
    cur_f0 & !is_burst;
  wire [15:0] f0_wdata = {wdata, rx_byte};
  wire f0_cfg = f0_wr & (reg_sel == `F0_CONFIG);
  wire f0_pad = f0_wr & (reg_sel == `F0_PAD);
  wire f0_ven = f0_wr & (reg_sel == `F0_VENDOR);
  wire f0_clr = f0_wr & (reg_sel == `F0_INT_CLEAR) &
    f0_wdata[`CLR_INT_BIT];

  // Function 0 read data
  wire [15:0] cfg_word = {15'h0000, len_en};
  wire [15:0] pad_word = {12'h000, pad_cnt};
  wire [15:0] ven_word = {13'h0000, wake_done_l, wake_req, sleep_allow};
  wire [15:0] f0_rdata = (reg_sel == `F0_CONFIG) ? cfg_word :
    (reg_sel == `F0_PAD) ? pad_word :
    (reg_sel == `F0_VENDOR) ? ven_word : 16'h0000;
  wire [15:0] rd_word = cur_f0 ? f0_rdata : ans_rdata;

  // Error byte for the current frame
  // zero unless busy, burst to function 0, or register read not ready or failed
  wire [7:0] busy_code = busy_now ? `ERR_BUSY : `ERR_OK;
  wire [7:0] rreg_code = (hdr_end | !done) ? `ERR_NOT_READY :
    ans_err ? `ERR_FAIL : `ERR_OK;
  wire [7:0] base_code = (is_burst & cur_f0) ? `ERR_TARGET :
    is_burst ? `ERR_OK : cur_f0 ? `ERR_OK : rreg_code;
  wire [7:0] err_now = base_code | busy_code;

  // Phase after the header
  wire [3:0] pad_last = pad_cnt - 4'h1;
  wire rd_to_err = (pad_cnt == 4'h0);
  wire [7:0] rd_tx = rd_to_err ? err_now : `PAD_BYTE;
  wire [7:0] burst_data = (moving & done) ? ans_rdata[7:0] : 8'h00;

  // Frame phase machine, one step per byte
  // command, then address
  always_ff @(posedge LINK_SCLK_IN or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state <= S_CMD;
      cmd <= 8'h00;
      addr <= 24'h000000;
      len_left <= 16'h0000;
      wdata <= 8'h00;
      fcnt <= 4'h0;
      tx <= 8'h00;
      bw_first <= 1'b0;
    end else begin
      tx <= {tx[6:0], 1'b0};
      if (rx_last) begin
        fcnt <= fcnt + 4'h1;
        case (state)
          S_CMD: begin
            cmd <= rx_byte;
            state <= S_ADDR;
            fcnt <= 4'h0;
            tx <= `PAD_BYTE;
          end
          S_ADDR: begin
            addr <= cur_addr;
            tx <= `PAD_BYTE;
          end
          S_LEN: begin
            len_left <= hdr_len;
            tx <= `PAD_BYTE;
          end
          S_WDATA: begin
            wdata <= rx_byte;
            tx <= `PAD_BYTE;
            if (fcnt == 4'h1) begin
              state <= S_ERR;
              tx <= cur_f0 ? `ERR_OK : busy_code;
            end
          end
          S_PAD: begin
            tx <= `PAD_BYTE;
            if (fcnt == pad_last) begin
              state <= S_ERR;
              tx <= err_now;
            end
          end
          S_ERR: begin
            fcnt <= 4'h0;
            if (is_write) begin
              state <= S_IDLE;
              tx <= 8'h00;
            end else if (is_burst) begin
              state <= S_BRD;
              tx <= burst_data;
              if (moving & len_en) begin
                len_left <= len_left - 16'h0001;
              end
            end else begin
              state <= S_RDATA;
              tx <= rd_word[15:8];
            end
          end
          S_RDATA: begin
            tx <= (fcnt == 4'h0) ? rd_word[7:0] : 8'h00;
            if (fcnt == 4'h1) begin
              state <= S_IDLE;
            end
          end
          S_BWR: begin
            tx <= 8'h00;
            if (moving) begin
              bw_first <= 1'b0;
              if (len_en) begin
                len_left <= len_left - 16'h0001;
              end
            end
          end
          S_BRD: begin
            tx <= burst_data;
            if (moving & len_en) begin
              len_left <= len_left - 16'h0001;
            end
          end
          S_IDLE: begin
            tx <= 8'h00;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
        // Enter the length phase
        if (len_go) begin
          state <= S_LEN;
          fcnt <= 4'h0;
        end
        // Enter the phase chosen by the command
        if (hdr_end) begin
          fcnt <= 4'h0;
          bw_first <= 1'b1;
          if (!is_burst) begin
            len_left <= 16'h0000;
          end
          if (is_write & is_burst) begin
            state <= S_BWR;
            tx <= err_now;
          end else if (is_write) begin
            state <= S_WDATA;
            tx <= `PAD_BYTE;
          end else begin
            state <= rd_to_err ? S_ERR : S_PAD;
            tx <= rd_tx;
          end
        end
      end
    end
  end

  // Request fields and function 0 registers
  // length enable cleared at reset
  always_ff @(posedge LINK_SCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      len_en <= `LEN_EN_RESET;
      pad_cnt <= `PAD_RESET;
      sleep_allow <= 1'b0;
      wake_req <= 1'b0;
      clr_tgl <= 1'b0;
      req_tgl <= 1'b0;
      q_addr <= 24'h000000;
      q_wdata <= 16'h0000;
      q_write <= 1'b0;
      q_burst <= 1'b0;
      q_start <= 1'b0;
    end else begin
      // Fields settle with the toggle, held until answered
      if (issue_go) begin
        req_tgl <= ~req_tgl;
        q_addr <= cur_addr;
        q_wdata <= issue_wdata;
        q_write <= issue_wr;
        q_burst <= is_burst;
        q_start <= issue_start;
      end
      if (f0_cfg) begin
        len_en <= f0_wdata[`CFG_LEN_EN_BIT];
      end
      if (f0_pad) begin
        pad_cnt <= f0_wdata[3:0];
      end
      // host sets sleep and wake bits
      if (f0_ven) begin
        sleep_allow <= f0_wdata[`VEN_SLEEP_BIT];
        wake_req <= f0_wdata[`VEN_WAKE_BIT];
      end
      if (f0_clr) begin
        clr_tgl <= ~clr_tgl;
      end
    end
  end

  // Output drive on the falling edge
  // change output on falling edge
  always_ff @(negedge LINK_SCLK_IN or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      MISO_OUT <= 1'b0;
      MISO_OE_OUT <= 1'b0;
    end else begin
      MISO_OUT <= tx[7];
      MISO_OE_OUT <= port_on;
    end
  end

  // Crossings into the core domain
  bit_sync u_req (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .d_in(req_tgl),
    .q_out(req_sync)
  );
  bit_sync u_clr (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .d_in(clr_tgl),
    .q_out(clr_sync)
  );
  bit_sync u_sleep (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .d_in(sleep_allow),
    .q_out(SLEEP_ALLOW_OUT)
  );
  bit_sync u_wake (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .d_in(wake_req),
    .q_out(WAKE_REQ_OUT)
  );

  // Core side decode
  wire req_edge = (req_sync != req_seen);
  wire clr_edge = (clr_sync != clr_seen);
  // pointer steps for each burst byte after the first
  wire [23:0] next_addr = (q_burst & !q_start) ? ptr + 24'h000001 : q_addr;
  wire acc_done = (cstate == C_WAIT) & ACC_ACK_IN;
  wire fail_set = acc_done & ACC_ERR_IN;
  wire wake_rise = WAKE_DONE_IN & !wake_seen;
  wire next_int = fail_set | wake_rise | (HOST_INT_OUT & !clr_edge);

  // Access sequencer on the core clock
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cstate <= C_IDLE;
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      ans_rdata <= 16'h0000;
      ans_err <= 1'b0;
      ptr <= 24'h000000;
      ACC_REQ_OUT <= 1'b0;
      ACC_BURST_OUT <= 1'b0;
      ACC_WRITE_OUT <= 1'b0;
      ACC_ADDR_OUT <= 24'h000000;
      ACC_WDATA_OUT <= 16'h0000;
    end else begin
      case (cstate)
        // Take a request, hold it until acknowledged
        C_IDLE: begin
          if (req_edge) begin
            req_seen <= req_sync;
            ptr <= next_addr;
            ACC_REQ_OUT <= 1'b1;
            ACC_BURST_OUT <= q_burst;
            ACC_WRITE_OUT <= q_write;
            ACC_ADDR_OUT <= next_addr;
            ACC_WDATA_OUT <= q_wdata;
            cstate <= C_WAIT;
          end
        end
        // Capture the answer and toggle back
        // slow or absent register read answer shows not ready
        C_WAIT: begin
          if (ACC_ACK_IN) begin
            ACC_REQ_OUT <= 1'b0;
            ans_rdata <= ACC_RDATA_IN;
            ans_err <= ACC_ERR_IN;
            ack_tgl <= ~ack_tgl;
            cstate <= C_IDLE;
          end
        end
        default: begin
          cstate <= C_IDLE;
        end
      endcase
    end
  end

  // Interrupt, mode latch and edge memories
  // mode fixed until reset
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      HOST_INT_OUT <= 1'b0;
      clr_seen <= 1'b0;
      wake_seen <= 1'b0;
      PORT_MODE_OUT <= 1'b0;
    end else begin
      HOST_INT_OUT <= next_int;
      clr_seen <= clr_sync;
      wake_seen <= WAKE_DONE_IN;
      PORT_MODE_OUT <= PORT_MODE_OUT | MODE_SELECT_IN;
    end
  end
endmodule

// ---- burst_spi_params.svh ----
`ifndef BURST_SPI_PARAMS_SVH
`define BURST_SPI_PARAMS_SVH

// Command field bits
`define CMD_BURST_BIT 7
`define CMD_WRITE_BIT 6
// Address bytes in a header and length bytes
`define ADDR_LAST_BYTE 4'h2
`define LEN_LAST_BYTE 4'h1
// Function number field of the address
`define FUNC_MSB 23
`define FUNC_LSB 16
`define FUNC_ZERO 8'h00
// Function 0 local register offsets
`define F0_CONFIG 8'h00
`define F0_PAD 8'h01
`define F0_VENDOR 8'h02
`define F0_INT_CLEAR 8'h03
// Function 0 field positions
`define CFG_LEN_EN_BIT 0
`define VEN_SLEEP_BIT 0
`define VEN_WAKE_BIT 1
`define VEN_DONE_BIT 2
`define CLR_INT_BIT 0
// Reset values
`define LEN_EN_RESET 1'b0
`define PAD_RESET 4'h0
// Error byte codes
`define ERR_OK 8'h00
`define ERR_FAIL 8'h01
`define ERR_NOT_READY 8'h02
`define ERR_TARGET 8'h04
`define ERR_BUSY 8'h08
// Padding byte value
`define PAD_BYTE 8'h00
`endif

// ---- burst_spi_pkg.sv ----
package burst_spi_pkg;
  // Link side frame phases
  typedef enum logic [3:0] {
    S_CMD = 4'b0000,
    S_ADDR = 4'b0001,
    S_LEN = 4'b0010,
    S_WDATA = 4'b0011,
    S_PAD = 4'b0100,
    S_ERR = 4'b0101,
    S_RDATA = 4'b0110,
    S_BWR = 4'b0111,
    S_BRD = 4'b1000,
    S_IDLE = 4'b1001
  } link_state_type;
  // Core side access phases
  typedef enum logic [0:0] {
    C_IDLE = 1'b0,
    C_WAIT = 1'b1
  } core_state_type;
endpackage

// ---- bit_sync.sv ----
`timescale 1ns/100ps
// Three-stage synchroniser, output moves once stages two and three agree
module bit_sync (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1; // Metastability catcher
  logic s2;
  logic s3;
  // Shift chain and agreement filter
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q_out <= 1'b0;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_out <= s3;
      end
    end
  end
endmodule

// ---- rx_shift.sv ----
`timescale 1ns/100ps
// Serial input byte assembler on the link clock
module rx_shift (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic bit_in,
  output logic [7:0] byte_out,
  output logic last_out
);
  logic [6:0] sh; // Bits gathered so far
  logic [2:0] cnt; // Bit position in the byte
  // Byte as it stands with the current bit
  assign byte_out = {sh, bit_in};
  assign last_out = (cnt == 3'h7);
  // Shift in, first bit is the most significant
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh <= 7'h00;
      cnt <= 3'h0;
    end else begin
      sh <= {sh[5:0], bit_in};
      cnt <= cnt + 3'h1;
    end
  end
endmodule

// ---- burst_spi_assertions.sv ----
`timescale 1ns/100ps
module burst_spi_checker (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PORT_SELECT_N_IN,
  input wire logic MISO_OUT,
  input wire logic MISO_OE_OUT,
  input wire logic MODE_SELECT_IN,
  input wire logic PORT_MODE_OUT,
  input wire logic ACC_REQ_OUT,
  input wire logic ACC_BURST_OUT,
  input wire logic [23:0] ACC_ADDR_OUT,
  input wire logic [15:0] ACC_WDATA_OUT,
  input wire logic ACC_ACK_IN,
  input wire logic ACC_ERR_IN,
  input wire logic WAKE_DONE_IN,
  input wire logic HOST_INT_OUT
);
  // Core clock samples everything
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  property p_req_hold;
    ACC_REQ_OUT && !ACC_ACK_IN |=> ACC_REQ_OUT && $stable(ACC_ADDR_OUT)
      && $stable(ACC_WDATA_OUT) && $stable(ACC_BURST_OUT);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before answer");
  property p_req_fall;
    ACC_REQ_OUT && ACC_ACK_IN |=> !ACC_REQ_OUT;
  endproperty
  a_req_fall: assert property (p_req_fall)
    else $error("request held after answer");
  property p_req_gap;
    $fell(ACC_REQ_OUT) |-> !ACC_REQ_OUT [*2];
  endproperty
  a_req_gap: assert property (p_req_gap)
    else $error("second access too soon");
  property p_burst_fn;
    ACC_REQ_OUT && ACC_BURST_OUT |-> ACC_ADDR_OUT[23:16] != 8'h00;
  endproperty
  a_burst_fn: assert property (p_burst_fn)
    else $error("burst reached function 0");
  property p_mode_set;
    MODE_SELECT_IN |-> ##[1:3] PORT_MODE_OUT;
  endproperty
  a_mode_set: assert property (p_mode_set)
    else $error("port mode not latched");
  property p_mode_stick;
    PORT_MODE_OUT |=> PORT_MODE_OUT;
  endproperty
  a_mode_stick: assert property (p_mode_stick)
    else $error("port mode lost");
  property p_int_err;
    ACC_REQ_OUT && ACC_ACK_IN && ACC_ERR_IN |-> ##[1:3] HOST_INT_OUT;
  endproperty
  a_int_err: assert property (p_int_err)
    else $error("failed access without interrupt");
  property p_int_wake;
    $rose(WAKE_DONE_IN) |-> ##[1:8] HOST_INT_OUT;
  endproperty
  a_int_wake: assert property (p_int_wake)
    else $error("wake done without interrupt");
  property p_oe_frame;
    MISO_OE_OUT |-> !PORT_SELECT_N_IN && PORT_MODE_OUT;
  endproperty
  a_oe_frame: assert property (p_oe_frame)
    else $error("output driven outside frame");
  property p_miso_idle;
    PORT_SELECT_N_IN |-> !MISO_OUT;
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("data out while deselected");
endmodule
bind burst_spi_host_slave burst_spi_checker checker_inst (.CLK_IN,
  .ARST_N_IN, .PORT_SELECT_N_IN, .MISO_OUT, .MISO_OE_OUT, .MODE_SELECT_IN,
  .PORT_MODE_OUT, .ACC_REQ_OUT, .ACC_BURST_OUT, .ACC_ADDR_OUT,
  .ACC_WDATA_OUT, .ACC_ACK_IN, .ACC_ERR_IN, .WAKE_DONE_IN, .HOST_INT_OUT);

// ---- spi_host_model.sv ----
`timescale 1ns/100ps
module spi_host_model (
  input wire logic miso_in,
  input wire logic miso_oe_in,
  output logic sclk_out,
  output logic sel_n_out,
  output logic mosi_out
);
  int gap = 0; // Clock stall between bytes, ns
  wire miso_line = miso_oe_in ? miso_in : 1'b1; // Weak pull-up
  // Clock idles low, select idles high
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  task open_f();
    #(1 + $urandom % 5);
    sel_n_out = 1'b0;
    #3;
  endtask
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_out = tx[i];
      #3 sclk_out = 1'b1;
      rx[i] = miso_line;
      #3 sclk_out = 1'b0;
    end
    #(gap);
  endtask
  task close_f();
    #3 sel_n_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
`include "burst_spi_params.svh"
module tb_top;
  logic clk = 0, arst_n = 0, mode_sel = 0, ack = 0, err_in = 0;
  logic wake_done = 0, ack_err = 0;
  logic [15:0] rdata = 16'h0000, rd_val = 16'h0000, wv;
  logic sclk, sel_n, mosi, miso, miso_oe, port_mode, req, burst, wr;
  logic sleep_allow, wake_req, host_int;
  logic [23:0] addr, av, ab;
  logic [15:0] wdata;
  logic [7:0] txb [0:31];
  logic [7:0] rxb [0:31];
  logic [23:0] log_addr [0:31];
  logic [15:0] log_data [0:31];
  logic [1:0] log_kind [0:31]; // Burst and write flags
  int n_fail = 0, total_checks = 0, n_req = 0, pads = 0, n0;
  // Core clock
  always #12.5 clk = ~clk;
  burst_spi_host_slave burst_spi_host_slave_inst (.CLK_IN(clk),
    .ARST_N_IN(arst_n), .LINK_SCLK_IN(sclk), .PORT_SELECT_N_IN(sel_n),
    .MOSI_IN(mosi), .MISO_OUT(miso), .MISO_OE_OUT(miso_oe),
    .MODE_SELECT_IN(mode_sel), .PORT_MODE_OUT(port_mode),
    .ACC_REQ_OUT(req), .ACC_BURST_OUT(burst), .ACC_WRITE_OUT(wr),
    .ACC_ADDR_OUT(addr), .ACC_WDATA_OUT(wdata), .ACC_ACK_IN(ack),
    .ACC_RDATA_IN(rdata), .ACC_ERR_IN(err_in),
    .SLEEP_ALLOW_OUT(sleep_allow), .WAKE_REQ_OUT(wake_req),
    .WAKE_DONE_IN(wake_done), .HOST_INT_OUT(host_int));
  spi_host_model spi_host_model_inst (.miso_in(miso), .miso_oe_in(miso_oe),
    .sclk_out(sclk), .sel_n_out(sel_n), .mosi_out(mosi));
  // Core side logs each access, answers after a random delay
  always begin
    @(posedge clk);
    #2;
    if (req === 1'b1) begin
      log_addr[n_req] = addr;
      log_data[n_req] = wdata;
      log_kind[n_req] = {burst, wr};
      n_req++;
      repeat ($urandom_range(2, 0)) begin
        @(posedge clk);
        #2;
      end
      ack = 1'b1;
      rdata = rd_val;
      err_in = ack_err;
      @(posedge clk);
      #2 ack = 1'b0;
      rdata = ~rdata;
      err_in = ~err_in;
      @(posedge clk);
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One frame: header then n bytes in total
  task frame(input logic [7:0] cmd, input logic [23:0] a, input int n);
    txb[0] = cmd;
    txb[1] = a[23:16];
    txb[2] = a[15:8];
    txb[3] = a[7:0];
    spi_host_model_inst.open_f();
    for (int i = 0; i < n; i++) spi_host_model_inst.xfer(txb[i], rxb[i]);
    spi_host_model_inst.close_f();
    repeat (12) @(posedge clk);
    #2;
  endtask
  task reg_wr(input logic [23:0] a, input logic [15:0] d);
    txb[4] = d[15:8];
    txb[5] = d[7:0];
    txb[6] = 8'h00;
    frame(8'h40, a, 7);
    check(rxb[6], `ERR_OK);
  endtask
  task reg_rd(input logic [23:0] a, input logic [15:0] d, input logic [7:0] e);
    for (int i = 4; i < 31; i++) txb[i] = 8'h00;
    frame(8'h00, a, 7 + pads);
    for (int i = 4; i < 4 + pads; i++) check(rxb[i], `PAD_BYTE);
    check(rxb[4 + pads], e);
    check({rxb[5 + pads], rxb[6 + pads]}, d);
  endtask
  // Hang guard
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h3969));
    repeat (8) @(posedge clk);
    #2 arst_n = 1'b1;
    check({port_mode, host_int}, 2'b00);
    for (int i = 0; i < 32; i++) txb[i] = 8'h00;
    // Frame before mode latch is ignored
    frame(8'h40, 24'h010000, 7);
    check({rxb[6], n_req[7:0]}, 16'hFF00);
    mode_sel = 1'b1;
    @(posedge clk);
    #2 mode_sel = 1'b0;
    frame(8'h00, 24'h000000, 4);
    check(port_mode, 1'b1);
    // Reset defaults: no pads, length field off
    reg_rd(24'h000000, 16'h0000, `ERR_OK);
    reg_wr(24'h000001, 16'h0008);
    pads = 8;
    reg_rd(24'h000001, 16'h0008, `ERR_OK);
    // Register write and read on function 1
    wv = $urandom;
    av = {8'h01, 16'($urandom)};
    reg_wr(av, wv);
    check({log_addr[0], log_kind[0]}, {av, 2'b01});
    check(log_data[0], wv);
    rd_val = $urandom;
    reg_rd(av ^ 24'h00FFFF, rd_val, `ERR_OK);
    check({log_addr[1], log_kind[1]}, {av ^ 24'h00FFFF, 2'b00});
    // Failed access sets, clear register clears
    ack_err = 1'b1;
    reg_rd(av, rd_val, `ERR_FAIL);
    ack_err = 1'b0;
    check(host_int, 1'b1);
    reg_wr(24'h000003, 16'h0001);
    check(host_int, 1'b0);
    // Burst write without length, slow host
    spi_host_model_inst.gap = 400;
    n0 = n_req;
    ab = {8'h02, 16'($urandom_range(16'hFF00))};
    for (int i = 4; i < 8; i++) txb[i] = $urandom;
    frame(8'hC0, ab, 8);
    check(rxb[4], `ERR_OK);
    for (int k = 0; k < 4; k++) begin
      check({log_addr[n0 + k], log_kind[n0 + k]}, {24'(ab + k), 2'b11});
      check(log_data[n0 + k][7:0], txb[4 + k]);
    end
    check(n_req - n0, 4);
    // Burst into function 0 refused
    frame(8'hC0, 24'h000010, 6);
    check({rxb[4], 8'(n_req - n0)}, {`ERR_TARGET, 8'h04});
    // Length field: zero moves nothing, extra bytes dropped
    reg_wr(24'h000000, 16'h0001);
    txb[5] = 8'h00;
    frame(8'hC0, ab, 8);
    check(n_req - n0, 4);
    txb[5] = 8'h01;
    txb[6] = $urandom;
    frame(8'hC0, ab, 9);
    check({rxb[6], 8'(n_req - n0)}, {`ERR_OK, 8'h05});
    check(log_data[n0 + 4][7:0], txb[6]);
    // Burst read of two bytes: pads, error, data, then nothing
    n0 = n_req;
    rd_val = $urandom;
    txb[4] = 8'h00;
    txb[5] = 8'h02;
    frame(8'h80, ab, 10 + pads);
    for (int i = 6; i < 6 + pads; i++) check(rxb[i], `PAD_BYTE);
    check(rxb[6 + pads], `ERR_OK);
    check({rxb[7 + pads], rxb[8 + pads]}, {2{rd_val[7:0]}});
    check(rxb[9 + pads], 8'h00);
    check({log_addr[n0], log_kind[n0]}, {ab, 2'b10});
    check({log_addr[n0 + 1], log_kind[n0 + 1]}, {24'(ab + 1), 2'b10});
    check(n_req - n0, 2);
    spi_host_model_inst.gap = 0;
    // Sleep permission, wake request, wake done
    reg_wr(24'h000002, 16'h0003);
    check({sleep_allow, wake_req}, 2'b11);
    wake_done = 1'b1;
    repeat (8) @(posedge clk);
    #2 check(host_int, 1'b1);
    reg_rd(24'h000002, 16'h0007, `ERR_OK);
    // Read answer cannot be back with no pad bytes
    reg_wr(24'h000001, 16'h0000);
    frame(8'h00, av, 7);
    check(rxb[4], `ERR_NOT_READY);
    // Reset drops latched mode
    arst_n = 1'b0;
    @(posedge clk);
    #2 check({port_mode, host_int}, 2'b00);
    arst_n = 1'b1;
    end_sim();
  end
endmodule
